// ===== design/rseq_consts.svh
`ifndef RSEQ_CONSTS_SVH
`define RSEQ_CONSTS_SVH

// Register offsets on the plain register port.
`define RSEQ_ADDR_CAUSE        8'h00
`define RSEQ_ADDR_STACK        8'h01
`define RSEQ_ADDR_STATE        8'h02

// Cause register reset value, write mask and fields.
`define RSEQ_CAUSE_RST         8'h1C
`define RSEQ_CAUSE_WMASK       8'h9F
`define RSEQ_CAUSE_PRIO_BIT    7
`define RSEQ_CAUSE_INSTR_BIT   4
`define RSEQ_CAUSE_WDT_BIT     3
`define RSEQ_CAUSE_SLEEP_BIT   2
`define RSEQ_CAUSE_PWRON_BIT   1
`define RSEQ_CAUSE_BROWN_BIT   0

// Stack status register field positions.
`define RSEQ_STACK_FULL_BIT    1
`define RSEQ_STACK_UNDER_BIT   0

// Clock and internal oscillator periods.
`define RSEQ_CLK_PERIOD_NS     4
`define RSEQ_INT_OSC_PERIOD_NS 1000

// Start-up times and derived counts, rounded up.
`define RSEQ_POWER_UP_DELAY_TIMER_TIME_MS      72
`define RSEQ_PLL_TIME_MS       2
`define RSEQ_WAKE_TIME_NS      1500
`define RSEQ_PIN_FILTER_NS     100
`define RSEQ_POWER_UP_DELAY_TIMER_TICKS  ((`RSEQ_POWER_UP_DELAY_TIMER_TIME_MS * 1000000 + `RSEQ_INT_OSC_PERIOD_NS - 1) / `RSEQ_INT_OSC_PERIOD_NS)
`define RSEQ_PLL_TICKS   ((`RSEQ_PLL_TIME_MS * 1000000 + `RSEQ_INT_OSC_PERIOD_NS - 1) / `RSEQ_INT_OSC_PERIOD_NS)
`define RSEQ_WAKE_CYCLES ((`RSEQ_WAKE_TIME_NS + `RSEQ_CLK_PERIOD_NS - 1) / `RSEQ_CLK_PERIOD_NS)
`define RSEQ_PIN_CYCLES  ((`RSEQ_PIN_FILTER_NS + `RSEQ_CLK_PERIOD_NS - 1) / `RSEQ_CLK_PERIOD_NS)

// Oscillator edge counts.
`define RSEQ_OST_EDGES         16'h0400
`define RSEQ_SWITCH_EDGES      16'h0008

`endif

// ===== design/rseq_pkg.sv
package rseq_pkg;

	// Main oscillator modes.
	typedef enum logic [2:0] {
		resistor_cap_osc_mode   = 3'h0,
		resistor_cap_io_mode    = 3'h1,
		ext_clock_mode          = 3'h2,
		ext_clock_io_mode       = 3'h3,
		high_speed_crystal_mode = 3'h4,
		standard_crystal_mode   = 3'h5,
		low_power_crystal_mode  = 3'h6
	} osc_mode_e;

	// Sequencer stages, one-hot.
	typedef enum logic [7:0] {
		st_hold    = 8'h01,
		st_pwrup   = 8'h02,
		st_oscwait = 8'h04,
		st_lock    = 8'h08,
		st_recover = 8'h10,
		st_switch  = 8'h20,
		st_sleep   = 8'h40,
		st_run     = 8'h80
	} seq_state_e;

	// Configuration bits.
	typedef struct packed {
		osc_mode_e mode;
		logic      pll_en;
		logic      power_delay_enable_n;
		logic      brownout_enable_bit;
	} cfg_s;

	// Reset-cause register layout.
	typedef struct packed {
		logic       irq_priority_enable;
		logic [1:0] spare;
		logic       reset_instr_flag_n;
		logic       watchdog_timeout_flag_n;
		logic       sleep_entered_flag_n;
		logic       power_on_flag_n;
		logic       brownout_flag_n;
	} cause_s;

endpackage

// ===== design/stage_counter.sv
`timescale 1ns/1ns
// Loadable down-counter that advances on qualified ticks.
module stage_counter #(
	parameter int W = 20
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_len,
	input  wire logic         i_tick,
	output logic              o_done
);

	logic [W-1:0] cnt;

	// Load wins over a tick so a restart always begins from the full length.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= '0;
		end else if (i_load) begin
			cnt <= i_len;
		end else if (i_tick && (cnt != '0)) begin
			cnt <= cnt - 1'b1;
		end
	end

	assign o_done = (cnt == '0);

endmodule // stage_counter

// ===== design/reset_powerup_sequencer.sv
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "rseq_consts.svh"

// Overview of operation
// RQ1 - Return to a non-crystal oscillator waits eight cycles.
// RQ2 - Sleep stops clocks and holds at the first quarter phase.
// RQ3 - Sleep ends on pin reset, watchdog or interrupt.
// RQ4 - In sleep the oscillator output is low, a port bit, or quiet.
// RQ5 - Enabled delay holds reset 72 ms after power-on or brown-out.
// RQ6 - PLL modes add a 2 ms lock wait after the start-up count.
// RQ7 - Cause flags get a distinct pattern per situation.
// RQ8 - True resets force designated state; wake-ups do not.
// RQ9 - Watchdog wake-up resumes without a reset.
// RQ10 - Reset pin is filtered against short pulses.
// RQ11 - Reset pin is never driven internally.
// RQ12 - Power-on pulse starts all time-outs.
// RQ13 - Delay counts on the internal oscillator, holding reset.
// RQ14 - 1024 input cycles are counted after the delay.
// RQ15 - Start-up count only for crystals, after power-on or wake.
// RQ16 - Enable bit gates brown-out; low supply holds reset.
// RQ17 - Delay restarts on recovery and on each new drop.
// RQ18 - Pin held low past time-outs starts execution at release.
// RQ19 - Wait is 1024 periods, plus 2 ms with PLL, plus 72 ms.
// RQ20 - External clock waits 1.5 us after sleep only; the code also waits it from hold when the delay and PLL are off.
// RQ21 - Cause register: priority bit 7, flags 4..0, 6..5 unused.
// RQ22 - Power-on sets instruction, watchdog, sleep flags; clears others.
// RQ23 - Reset releases when every source and stage is done.
module reset_powerup_sequencer #(
	parameter int CNT_W      = 20,
	parameter int POWER_UP_DELAY_TIMER_TICKS = `RSEQ_POWER_UP_DELAY_TIMER_TICKS,
	parameter int PLL_TICKS  = `RSEQ_PLL_TICKS
) (
	input  wire logic          i_ref_clk,
	input  wire logic          i_rst_n,
	input  wire rseq_pkg::cfg_s i_cfg,
	input  wire logic          i_por_pulse,
	input  wire logic          i_supply_low,
	input  wire logic          i_ext_reset_pin_n,
	input  wire logic          i_wdt_timeout,
	input  wire logic          i_reset_instr,
	input  wire logic          i_stack_full,
	input  wire logic          i_stack_underflow,
	input  wire logic          i_sleep_instr,
	input  wire logic          i_irq_wake,
	input  wire logic          i_osc_return,
	input  wire logic          i_osc_in_pin,
	input  wire logic          i_int_osc,
	input  wire logic          i_fosc_div4,
	input  wire logic          i_porta6_out,
	input  wire logic          i_porta6_oe,
	input  wire logic [7:0]    i_reg_addr,
	input  wire logic [7:0]    i_reg_wdata,
	input  wire logic          i_reg_we,
	input  wire logic          i_reg_re,
	output logic               o_core_reset,
	output logic               o_cold_reset,
	output logic               o_clocks_run,
	output logic               o_hold_first_quarter_phase,
	output logic               o_wake_resume,
	output logic               o_osc_out_pin_o,
	output logic               o_osc_out_pin_oe,
	output logic               o_osc_feedback_en,
	output logic               o_ext_reset_pin_o,
	output logic               o_ext_reset_pin_oe,
	output logic               o_irq_priority_enable,
	output logic [7:0]         o_reg_rdata
);
	import rseq_pkg::*;

	seq_state_e state;
	seq_state_e state_d;
	cause_s     cause;
	logic       stack_full_flag;
	logic       stack_under_flag;
	logic       cold;
	logic       resuming;
	logic       switching;
	logic       int_rst;
	logic       osc_q;
	logic       int_osc_q;
	logic       pin_filt;
	logic       pin_filt_d;
	logic       osc_rise;
	logic       int_rise;
	logic       entered;
	logic       crystal;
	logic       ext_clk;
	logic       pll_on;
	logic       brownout_active;
	logic       pin_fall;
	logic       run_event;
	logic       int_load;
	logic       osc_load;
	logic       clk_load;
	logic       pin_load;
	logic       int_done;
	logic       osc_done;
	logic       clk_done;
	logic       pin_done;
	logic [CNT_W-1:0] int_len;
	logic [CNT_W-1:0] osc_len;

	// Mode decode; the PLL exists only in the high-speed crystal and external-clock modes.
	assign crystal = (i_cfg.mode == high_speed_crystal_mode) || (i_cfg.mode == standard_crystal_mode) ||
		(i_cfg.mode == low_power_crystal_mode);
	assign ext_clk = (i_cfg.mode == ext_clock_mode) || (i_cfg.mode == ext_clock_io_mode);
	assign pll_on  = i_cfg.pll_en && ((i_cfg.mode == high_speed_crystal_mode) || ext_clk);
	assign brownout_active = i_cfg.brownout_enable_bit && i_supply_low; // RQ16

	// Edge detection on the oscillator input and on the internal oscillator.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			osc_q     <= 1'b0;
			int_osc_q <= 1'b0;
		end else begin
			osc_q     <= i_osc_in_pin;
			int_osc_q <= i_int_osc;
		end
	end
	assign osc_rise = i_osc_in_pin && !osc_q;
	assign int_rise = i_int_osc && !int_osc_q; // RQ13

	// Counters load on stage entry; done is ignored in that cycle.
	assign entered  = (state != state_d);
	assign int_load = entered && ((state == st_pwrup) || (state == st_lock));
	assign osc_load = entered && ((state == st_oscwait) || (state == st_switch));
	assign clk_load = entered && (state == st_recover);
	assign int_len  = (state == st_lock) ? CNT_W'(PLL_TICKS) : CNT_W'(POWER_UP_DELAY_TIMER_TICKS); // RQ5 RQ6
	assign osc_len  = (state == st_switch) ? CNT_W'(`RSEQ_SWITCH_EDGES) : CNT_W'(`RSEQ_OST_EDGES); // RQ1 RQ14

	// Power-up delay and lock wait count internal oscillator ticks.
	stage_counter #(.W(CNT_W)) u_int_cnt (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_load    (int_load),
		.i_len     (int_len),
		.i_tick    (int_rise),
		.o_done    (int_done)
	);

	// Start-up and switch counts use rising edges of the oscillator input.
	stage_counter #(.W(CNT_W)) u_osc_cnt (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_load    (osc_load),
		.i_len     (osc_len),
		.i_tick    (osc_rise),
		.o_done    (osc_done)
	);

	// Sleep recovery in external-clock mode without the PLL is timed on the reference clock.
	stage_counter #(.W(CNT_W)) u_clk_cnt (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_load    (clk_load),
		.i_len     (CNT_W'(`RSEQ_WAKE_CYCLES)), // RQ20
		.i_tick    (1'b1),
		.o_done    (clk_done)
	);

	// The filter counter reloads while the pin matches the filtered level.
	assign pin_load = (i_ext_reset_pin_n == pin_filt);
	stage_counter #(.W(CNT_W)) u_pin_cnt (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_load    (pin_load),
		.i_len     (CNT_W'(`RSEQ_PIN_CYCLES)),
		.i_tick    (1'b1),
		.o_done    (pin_done)
	);

	// A pin change is accepted only after it has stood for the whole filter time.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_filt   <= 1'b1;
			pin_filt_d <= 1'b1;
		end else begin
			if (!pin_load && pin_done) begin
				pin_filt <= i_ext_reset_pin_n; // RQ10
			end
			pin_filt_d <= pin_filt;
		end
	end
	assign pin_fall  = pin_filt_d && !pin_filt;
	assign run_event = i_wdt_timeout || i_reset_instr || i_stack_full || i_stack_underflow;

	// Power-on and brown-out restart the sequence from the hold stage.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state     <= st_hold;
			state_d   <= st_hold;
			cold      <= 1'b1;
			resuming  <= 1'b0;
			switching <= 1'b0;
		end else begin
			state_d <= state;
			if (i_por_pulse || brownout_active) begin
				state     <= st_hold; // RQ12 RQ16 RQ17
				cold      <= 1'b1;
				resuming  <= 1'b0;
				switching <= 1'b0;
			end else begin
				unique case (state)
					st_hold: begin
						if (!i_cfg.power_delay_enable_n) begin
							state <= st_pwrup; // RQ5 RQ13
						end else if (crystal) begin
							state <= st_oscwait; // RQ15 RQ19
						end else if (pll_on) begin
							state <= st_lock;
						end else if (ext_clk) begin
							state <= st_recover;
						end else begin
							state <= st_run;
						end
					end
					st_pwrup: begin
						if (!entered && int_done) begin
							if (crystal) begin
								state <= st_oscwait; // RQ14
							end else if (pll_on) begin
								state <= st_lock; // RQ6
							end else begin
								state <= st_run;
							end
						end
					end
					st_oscwait: begin
						if (!entered && osc_done) begin
							state <= pll_on ? st_lock : st_run; // RQ6 RQ19
						end
					end
					st_lock: begin
						if (!entered && int_done) begin
							state <= st_run; // RQ6
						end
					end
					st_recover, st_switch: begin
						if (!entered && ((state == st_recover) ? clk_done : osc_done)) begin
							state <= st_run; // RQ1 RQ20
						end
					end
					st_sleep: begin
						if (!pin_filt) begin
							state <= st_run; // RQ3
						end else if (i_wdt_timeout || i_irq_wake) begin
							resuming <= 1'b1; // RQ3 RQ9
							if (crystal) begin
								state <= st_oscwait; // RQ15
							end else if (pll_on) begin
								state <= st_lock;
							end else if (ext_clk) begin
								state <= st_recover; // RQ20
							end else begin
								state <= st_run;
							end
						end
					end
					st_run: begin
						cold      <= 1'b0;
						resuming  <= 1'b0;
						switching <= 1'b0;
						if (pin_filt && !run_event && i_sleep_instr) begin
							state <= st_sleep; // RQ2
						end else if (pin_filt && !run_event && i_osc_return) begin
							switching <= 1'b1;
							state     <= crystal ? st_oscwait : st_switch; // RQ1 RQ20
						end
					end
					default: begin
						state <= st_hold;
					end
				endcase
			end
		end
	end

	// One-cycle internal reset for run-time faults.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			int_rst <= 1'b0;
		end else begin
			int_rst <= (state == st_run) && run_event;
		end
	end

	// Cause and stack flags; hardware events follow the write, so they win.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cause            <= cause_s'(`RSEQ_CAUSE_RST);
			stack_full_flag  <= 1'b0;
			stack_under_flag <= 1'b0;
		end else begin
			if (i_reg_we && (i_reg_addr == `RSEQ_ADDR_CAUSE)) begin
				cause <= cause_s'(i_reg_wdata & `RSEQ_CAUSE_WMASK); // RQ21
			end
			if (i_reg_we && (i_reg_addr == `RSEQ_ADDR_STACK)) begin
				stack_full_flag  <= i_reg_wdata[`RSEQ_STACK_FULL_BIT];
				stack_under_flag <= i_reg_wdata[`RSEQ_STACK_UNDER_BIT];
			end
			if (i_por_pulse) begin
				cause.reset_instr_flag_n      <= 1'b1; // RQ22 RQ7
				cause.watchdog_timeout_flag_n <= 1'b1;
				cause.sleep_entered_flag_n    <= 1'b1;
				cause.power_on_flag_n         <= 1'b0;
				cause.brownout_flag_n         <= 1'b0;
			end else if (brownout_active) begin
				cause.brownout_flag_n <= 1'b0; // RQ22
			end else if (state == st_sleep) begin
				if (pin_fall || i_irq_wake) begin
					cause.watchdog_timeout_flag_n <= 1'b1; // RQ7
					cause.sleep_entered_flag_n    <= 1'b0;
				end else if (i_wdt_timeout) begin
					cause.watchdog_timeout_flag_n <= 1'b0; // RQ7 RQ9
					cause.sleep_entered_flag_n    <= 1'b0;
				end
			end else if ((state == st_run) && pin_filt) begin
				if (i_wdt_timeout) begin
					cause.reset_instr_flag_n      <= 1'b1; // RQ7
					cause.watchdog_timeout_flag_n <= 1'b0;
					cause.sleep_entered_flag_n    <= 1'b1;
				end else if (i_reset_instr) begin
					cause.reset_instr_flag_n <= 1'b0; // RQ7
				end else if (i_stack_full) begin
					stack_full_flag <= 1'b1;
				end else if (i_stack_underflow) begin
					stack_under_flag <= 1'b1;
				end else if (i_sleep_instr) begin
					cause.watchdog_timeout_flag_n <= 1'b1;
					cause.sleep_entered_flag_n    <= 1'b0;
				end
			end
		end
	end

	// Wake and switch stages freeze the core rather than reset it.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_core_reset               <= 1'b1;
			o_cold_reset               <= 1'b1;
			o_clocks_run               <= 1'b1;
			o_hold_first_quarter_phase <= 1'b0;
			o_wake_resume              <= 1'b0;
		end else begin
			o_core_reset <= i_por_pulse || brownout_active || !pin_filt || int_rst ||
				(!resuming && !switching && (state != st_run) && (state != st_sleep)); // RQ8 RQ18 RQ23
			o_cold_reset <= cold || i_por_pulse || brownout_active; // RQ8
			o_clocks_run <= (state != st_sleep); // RQ2
			o_hold_first_quarter_phase <= (state == st_sleep) ||
				((resuming || switching) && (state != st_run)); // RQ2 RQ1
			o_wake_resume <= resuming && (state == st_run); // RQ9
		end
	end

	// In sleep the oscillator output is low, a port bit, or left quiet.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_osc_out_pin_o   <= 1'b0;
			o_osc_out_pin_oe  <= 1'b0;
			o_osc_feedback_en <= 1'b1;
		end else begin
			o_osc_feedback_en <= !(crystal && (state == st_sleep)); // RQ4
			if (crystal) begin
				o_osc_out_pin_o  <= 1'b0;
				o_osc_out_pin_oe <= 1'b0;
			end else if ((i_cfg.mode == resistor_cap_io_mode) || (i_cfg.mode == ext_clock_io_mode)) begin
				o_osc_out_pin_o  <= i_porta6_out; // RQ4
				o_osc_out_pin_oe <= i_porta6_oe;
			end else begin
				o_osc_out_pin_o  <= (state != st_sleep) && i_fosc_div4; // RQ4
				o_osc_out_pin_oe <= 1'b1;
			end
		end
	end

	// The reset pin is input only; no internal reset ever pulls it.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ext_reset_pin_o  <= 1'b0;
			o_ext_reset_pin_oe <= 1'b0;
		end else begin
			o_ext_reset_pin_o  <= 1'b0; // RQ11
			o_ext_reset_pin_oe <= 1'b0; // RQ11
		end
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata           <= 8'h00;
			o_irq_priority_enable <= 1'b0;
		end else begin
			o_irq_priority_enable <= cause.irq_priority_enable;
			if (!i_reg_re) begin
				o_reg_rdata <= 8'h00;
			end else if (i_reg_addr == `RSEQ_ADDR_CAUSE) begin
				o_reg_rdata <= cause & `RSEQ_CAUSE_WMASK; // RQ21
			end else if (i_reg_addr == `RSEQ_ADDR_STACK) begin
				o_reg_rdata <= {6'h00, stack_full_flag, stack_under_flag};
			end else if (i_reg_addr == `RSEQ_ADDR_STATE) begin
				o_reg_rdata <= state;
			end else begin
				o_reg_rdata <= 8'h00;
			end
		end
	end

endmodule // reset_powerup_sequencer

// ===== test/rseq_monitor.sv
`timescale 1ns/1ns
// Port checker; pin run lengths back the filter checks.
module rseq_monitor
	import rseq_pkg::*;
(
	input wire logic           i_ref_clk,
	input wire logic           i_rst_n,
	input wire rseq_pkg::cfg_s i_cfg,
	input wire logic           i_por_pulse,
	input wire logic           i_supply_low,
	input wire logic           i_ext_reset_pin_n,
	input wire logic           i_sleep_instr,
	input wire logic           i_reg_re,
	input wire logic           o_core_reset,
	input wire logic           o_cold_reset,
	input wire logic           o_clocks_run,
	input wire logic           o_hold_first_quarter_phase,
	input wire logic           o_wake_resume,
	input wire logic           o_osc_out_pin_o,
	input wire logic           o_osc_out_pin_oe,
	input wire logic           o_ext_reset_pin_o,
	input wire logic           o_ext_reset_pin_oe,
	input wire logic [7:0]     o_reg_rdata
);
	logic [5:0] lo_cnt;
	logic [5:0] hi_cnt;

	default clocking mon_clk @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	// Saturating run lengths of each pin level.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lo_cnt <= 6'h00;
			hi_cnt <= 6'h3F;
		end else begin
			lo_cnt <= i_ext_reset_pin_n ? 6'h00 : lo_cnt + {5'h00, lo_cnt != 6'h3F};
			hi_cnt <= !i_ext_reset_pin_n ? 6'h00 : hi_cnt + {5'h00, hi_cnt != 6'h3F};
		end
	end

	a_pin_undriven: assert property (!o_ext_reset_pin_oe && !o_ext_reset_pin_o) else $error("reset pin driven");
	a_rdata_idle: assert property (!$past(i_reg_re) |-> o_reg_rdata == 8'h00) else $error("stray read data");
	a_por_cold: assert property (i_por_pulse |=> o_core_reset && o_cold_reset) else $error("no cold reset");
	a_brown_hold: assert property (i_cfg.brownout_enable_bit && i_supply_low |=> o_core_reset)
		else $error("no brown-out hold");
	a_pin_long: assert property (lo_cnt >= 6'd30 |-> o_core_reset) else $error("long pin low ignored");
	a_release_filtered: assert property ($fell(o_core_reset) |-> hi_cnt >= 6'd25)
		else $error("early release");
	a_sleep_frozen: assert property (!o_clocks_run |-> o_hold_first_quarter_phase) else $error("core not frozen");
	a_sleep_cause: assert property ($fell(o_clocks_run) |-> $past(i_sleep_instr) || $past(i_sleep_instr, 2))
		else $error("clocks stopped without sleep");
	a_sleep_oscpin: assert property (!o_clocks_run && !$past(o_clocks_run)
		&& (i_cfg.mode == resistor_cap_osc_mode || i_cfg.mode == ext_clock_mode) |-> o_osc_out_pin_oe && !o_osc_out_pin_o)
		else $error("osc output not low in sleep");
	a_wake_warm: assert property (o_wake_resume |-> !o_core_reset ##1 !o_wake_resume) else $error("wake not warm");

	c_sleep: cover property ($fell(o_clocks_run));
	c_wake: cover property (o_wake_resume);
	c_release: cover property ($fell(o_core_reset));
endmodule // rseq_monitor

bind reset_powerup_sequencer rseq_monitor mon (.*);

// ===== test/rseq_partner.sv
`timescale 1ns/1ns
// Main and internal oscillators plus the pulled-up external reset pin.
module rseq_partner #(
	parameter int OSC_HALF_NS = 6,
	parameter int INT_HALF_NS = 20
) (
	input  wire logic i_pull_low,
	input  wire logic i_pin_o,
	input  wire logic i_pin_oe,
	input  wire logic i_osc_stop,
	output logic      o_pin_n,
	output wire logic o_osc_in,
	output logic      o_int_osc
);
	logic osc;

	// Pulled-up pin; a device drive wins.
	assign o_pin_n = i_pin_oe ? i_pin_o : !i_pull_low;
	assign o_osc_in = osc;
	// Stops in sleep so no stray edges count.
	initial begin
		osc = 1'b0;
		#1;
		forever #(OSC_HALF_NS) osc = i_osc_stop ? 1'b0 : !osc;
	end
	// Internal source runs free, off the core clock phase.
	initial begin
		o_int_osc = 1'b0;
		#3;
		forever #(INT_HALF_NS) o_int_osc = !o_int_osc;
	end
endmodule // rseq_partner

// ===== test/testbench.sv
`timescale 1ns/1ns
`include "rseq_consts.svh"
// Self-checking bench for the reset and power-up sequencer.
module testbench;
	import rseq_pkg::*;
	localparam int POWER_UP_DELAY_TIMER   = 20;
	localparam int PLL    = 5;
	localparam int OSC_NS = 12;
	localparam int INT_NS = 40;
	logic       i_ref_clk, i_rst_n, supply_low, pull_low, we, re;
	logic       core_reset, cold_reset, clocks_run, hold, wake, osc_o, osc_oe, fb_en, pin_o, pin_oe, prio;
	logic [6:0] ev;
	logic [7:0] addr, wdata, rdata, g, c, d;
	cfg_s       cfg;
	wire        pin_n, osc_in, int_osc;
	int         err_total, checks_done, cycles, seed, t;

	reset_powerup_sequencer #(.POWER_UP_DELAY_TIMER_TICKS(POWER_UP_DELAY_TIMER), .PLL_TICKS(PLL)) uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_cfg(cfg), .i_por_pulse(ev[6]), .i_supply_low(supply_low), .i_ext_reset_pin_n(pin_n),
		.i_wdt_timeout(ev[0]), .i_reset_instr(ev[1]), .i_stack_full(ev[2]), .i_stack_underflow(1'b0),
		.i_sleep_instr(ev[3]), .i_irq_wake(ev[4]), .i_osc_return(ev[5]), .i_osc_in_pin(osc_in),
		.i_int_osc(int_osc), .i_fosc_div4(1'b0), .i_porta6_out(1'b0), .i_porta6_oe(1'b0), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_we(we), .i_reg_re(re), .o_core_reset(core_reset), .o_cold_reset(cold_reset),
		.o_clocks_run(clocks_run), .o_hold_first_quarter_phase(hold), .o_wake_resume(wake),
		.o_osc_out_pin_o(osc_o), .o_osc_out_pin_oe(osc_oe), .o_osc_feedback_en(fb_en),
		.o_ext_reset_pin_o(pin_o), .o_ext_reset_pin_oe(pin_oe), .o_irq_priority_enable(prio), .o_reg_rdata(rdata));
	rseq_partner #(.OSC_HALF_NS(OSC_NS / 2), .INT_HALF_NS(INT_NS / 2)) far (.i_pull_low(pull_low),
		.i_pin_o(pin_o), .i_pin_oe(pin_oe), .i_osc_stop(!clocks_run), .o_pin_n(pin_n), .o_osc_in(osc_in),
		.o_int_osc(int_osc));

	// Core clock and a cycle count.
	initial begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = !i_ref_clk;
	end
	always @(posedge i_ref_clk) cycles <= cycles + 1;

	task complete_run;
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk8(input string n, input logic [7:0] e, input logic [7:0] s);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task chk_ge(input string n, input int s, input int e);
		checks_done++;
		if (s < e) begin
			err_total++;
			$display("CHECK FAILED %s expected at least %0d seen %0d", n, e, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	task pulse(input int k);
		@(posedge i_ref_clk);
		ev <= 7'(1 << k);
		@(posedge i_ref_clk);
		ev <= 7'h00;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_ref_clk);
		addr <= a;
		wdata <= v;
		we <= 1'b1;
		@(posedge i_ref_clk);
		we <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge i_ref_clk);
		addr <= a;
		re <= 1'b1;
		@(posedge i_ref_clk);
		re <= 1'b0;
		#1;
		v = rdata;
	endtask
	// Condition a bounded wait looks for.
	function automatic logic pick(input int k);
		case (k)
			0: pick = core_reset === 1'b0;
			1: pick = wake === 1'b1;
			default: pick = hold === 1'b0;
		endcase
	endfunction
	task wait_for(input int k, input int bound);
		int n;
		n = 0;
		while (!pick(k) && n < bound) begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		if (n >= bound) begin
			err_total++;
			$display("CHECK FAILED wait %0d expected done seen timeout", k);
			complete_run();
		end
	endtask
	task wait_state(input logic [7:0] s, input int bound);
		int n;
		n = 0;
		g = 8'h00;
		while (g !== s && n < bound) begin
			rd(`RSEQ_ADDR_STATE, g);
			n++;
		end
		chk8("state", s, g);
		if (g !== s) complete_run();
	endtask
	// Cause after event: 0-2 run resets, 3 sleep, 4/5 wakes, 6 power-on, 7 brown-out.
	function automatic logic [7:0] next_cause(input logic [7:0] v, input int k);
		next_cause = v;
		case (k)
			0: next_cause[4:2] = 3'b101;
			1: next_cause[4] = 1'b0;
			3, 4: next_cause[3:2] = 2'b10;
			5: next_cause[3:2] = 2'b00;
			6: next_cause = 8'h1C;
			7: next_cause[0] = 1'b0;
			default: ;
		endcase
	endfunction
	// Shortest cold start in cycles; one tick slack per stage.
	function automatic int min_wait(input cfg_s f);
		min_wait = 0;
		if (!f.power_delay_enable_n) min_wait += (POWER_UP_DELAY_TIMER - 1) * INT_NS;
		if (f.mode >= high_speed_crystal_mode) min_wait += 1023 * OSC_NS;
		if (f.pll_en) min_wait += (PLL - 1) * INT_NS;
		min_wait = min_wait / `RSEQ_CLK_PERIOD_NS;
	endfunction

	initial begin
		{err_total, checks_done, cycles, t} = '0;
		seed = 15;
		cfg = '{resistor_cap_osc_mode, 1'b0, 1'b1, 1'b1};
		{i_rst_n, supply_low, pull_low, we, re, ev, addr, wdata} = '0;
		cyc(10);
		i_rst_n <= 1'b1;
		wait_for(0, 100);
		rd(`RSEQ_ADDR_CAUSE, g);
		chk8("cause reset", 8'h1C, g);
		for (int i = 0; i < 6; i++) begin
			d = 8'($random(seed));
			wr(`RSEQ_ADDR_CAUSE, d);
			rd(`RSEQ_ADDR_CAUSE, g);
			chk8("cause rw", d & `RSEQ_CAUSE_WMASK, g);
			chk8("prio", {7'h00, d[7]}, {7'h00, prio});
		end
		wr(`RSEQ_ADDR_STATE, 8'h00);
		wait_state(st_run, 1);
		rd(8'h5A, g);
		chk8("unmapped", 8'h00, g);
		wr(`RSEQ_ADDR_CAUSE, 8'h1F);
		c = 8'h1F;
		// A short pin pulse is filtered; a long one resets until release.
		pull_low <= 1'b1;
		cyc(3 + 32'($unsigned($random(seed))) % 18);
		pull_low <= 1'b0;
		cyc(30);
		chk8("glitch", 8'h00, {7'h00, core_reset});
		pull_low <= 1'b1;
		cyc(60);
		pull_low <= 1'b0;
		t = cycles;
		wait_for(0, 200);
		chk_ge("pin release", cycles - t, 25);
		for (int k = 0; k < 3; k++) begin
			pulse(k);
			cyc(3);
			wait_for(0, 200);
			c = next_cause(c, k);
			rd(`RSEQ_ADDR_CAUSE, g);
			chk8("cause event", c, g);
		end
		rd(`RSEQ_ADDR_STACK, g);
		chk8("stack full", 8'h02, g & 8'h02);
		// Sleep twice: woken by an interrupt, then by the watchdog.
		for (int j = 0; j < 2; j++) begin
			pulse(3);
			cyc(3);
			chk8("sleep clocks", 8'h00, {7'h00, clocks_run});
			chk8("sleep osc pin", 8'h02, {6'h00, osc_oe, osc_o});
			c = next_cause(c, 3);
			rd(`RSEQ_ADDR_CAUSE, g);
			chk8("cause sleep", c, g);
			pulse(j == 0 ? 4 : 0);
			wait_for(1, 100);
			chk8("warm wake", 8'h00, {7'h00, core_reset});
			c = next_cause(c, 4 + j);
			rd(`RSEQ_ADDR_CAUSE, g);
			chk8("cause wake", c, g);
		end
		pulse(5);
		t = cycles;
		cyc(2);
		chk8("switch hold", 8'h02, {6'h00, hold, core_reset});
		wait_for(2, 200);
		chk_ge("switch", cycles - t, 7 * OSC_NS / `RSEQ_CLK_PERIOD_NS);
		// Brown-out, then a second drop in mid-delay.
		cfg.power_delay_enable_n <= 1'b0;
		supply_low <= 1'b1;
		cyc(5);
		wait_state(st_hold, 1);
		supply_low <= 1'b0;
		wait_state(st_pwrup, 20);
		supply_low <= 1'b1;
		cyc(3);
		wait_state(st_hold, 1);
		supply_low <= 1'b0;
		t = cycles;
		wait_for(0, 1000);
		chk_ge("delay", cycles - t, min_wait(cfg));
		c = next_cause(c, 7);
		rd(`RSEQ_ADDR_CAUSE, g);
		chk8("cause brown", c, g);
		cfg.brownout_enable_bit <= 1'b0;
		supply_low <= 1'b1;
		cyc(5);
		chk8("brown off", 8'h00, {7'h00, core_reset});
		supply_low <= 1'b0;
		// Cold start through the power-up, start-up and lock stages.
		cfg <= '{high_speed_crystal_mode, 1'b1, 1'b0, 1'b1};
		cyc(2);
		pulse(6);
		t = cycles;
		wait_state(st_pwrup, 20);
		wait_state(st_oscwait, 400);
		wait_state(st_lock, 2000);
		wait_state(st_run, 200);
		wait_for(0, 50);
		chk_ge("cold start", cycles - t, min_wait(cfg));
		rd(`RSEQ_ADDR_CAUSE, g);
		chk8("cause por", next_cause(c, 6), g);
		complete_run();
	end
endmodule // testbench
